// >>> bench/irm_xcvr_model.sv
`timescale 1ns/10ps
// ****************************************
// infrared transceiver model
// ****************************************
module irm_xcvr_model (
   input wire logic mclk,
   input wire logic ir_tx_pin,
   input wire logic idle_lvl,
   output logic ir_rx_pin,
   output logic pulse_seen,
   output logic [15:0] pulse_len
);
   logic busy_r = 1'b0; // optical pulse in progress
   logic [15:0] run_r = 16'h0000; // clocks the emitter is lit
   // receiver output rests at idle level, inverted while a send_pulse pulse is in progress
   assign ir_rx_pin = busy_r ? ~idle_lvl : idle_lvl;
   // one optical pulse of len clocks, called just after an edge
   task automatic send_pulse(input int len);
      busy_r <= 1'b1;
      repeat (len) @(posedge mclk);
      busy_r <= 1'b0;
   endtask
   // width of each emitted pulse in clocks
   always @(posedge mclk) begin
      run_r <= ir_tx_pin ? run_r + 16'h0001 : 16'h0000;
      pulse_seen <= !ir_tx_pin && run_r != 16'h0000;
      pulse_len <= run_r;
   end
endmodule // irm_xcvr_model

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`include "irm_defs.svh"
module tb_top import irm_pkg::*;;
   localparam int DEPTH = 8; // transmit fifo words
   logic mclk;
   logic reset;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic tx_bit_valid;
   logic tx_bit_data;
   logic tx_bit_ready;
   logic ir_tx_pin;
   logic ir_rx_pin;
   logic uart_rxd;
   logic idle_lvl; // receiver idle level, follows polarity
   logic pulse_seen;
   logic [15:0] pulse_len;
   logic rd_seen = 1'b0; // read strobe taken last edge
   logic rxd_d = 1'b1; // previous demodulated level
   logic [31:0] seed = 32'h0000211B; // random source
   logic [7:0] rd_q[$]; // expected read data
   logic [15:0] tx_q[$]; // expected pulse widths
   int n_fail = 0;
   int n_compared = 0;
   int n_falls = 0; // zeros presented to the channel
   // ****************************************
   // design and far side
   // ****************************************
   irm_modem #(.FIFO_DEPTH(DEPTH)) dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_bit_valid(tx_bit_valid), .tx_bit_data(tx_bit_data), .tx_bit_ready(tx_bit_ready),
      .ir_tx_pin(ir_tx_pin), .ir_rx_pin(ir_rx_pin), .uart_rxd(uart_rxd));
   irm_xcvr_model xcvr_u (.mclk(mclk), .ir_tx_pin(ir_tx_pin), .idle_lvl(idle_lvl),
      .ir_rx_pin(ir_rx_pin), .pulse_seen(pulse_seen), .pulse_len(pulse_len));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rd_q.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic close_out();
      $display("Counts: compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ****************************************
   // clock, monitors, watchdog
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (rd_seen) chk({8'h00, reg_rdata}, {8'h00, rd_q.pop_front()});
      rd_seen <= reg_rd;
      rxd_d <= uart_rxd;
      if (rxd_d === 1'b1 && uart_rxd === 1'b0) n_falls++;
      // each emitted pulse must belong to a zero bit
      if (pulse_seen === 1'b1) chk(pulse_len, (tx_q.size() > 0) ? tx_q.pop_front() : 16'h0000);
   end
   initial begin
      #100000;
      n_fail++;
      close_out();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      irm_ctrl_t ctl;
      logic [15:0] w;
      logic b;
      int n;
      int mn;
      int f0;
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_bit_valid = 1'b0;
      tx_bit_data = 1'b0;
      idle_lvl = 1'b0;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      chk({15'h0000, uart_rxd}, 16'h0001);
      rd(`IRM_ADDR_CTRL, `IRM_CTRL_RST);
      rd(`IRM_ADDR_DIV, `IRM_DIV_RST);
      rd(`IRM_ADDR_STAT, `IRM_READ_ZERO);
      wr(8'h03, 8'hFF);
      rd(8'h03, `IRM_READ_ZERO);
      rd(`IRM_ADDR_CTRL, `IRM_CTRL_RST);
      // transmit: 3/16 at divisor 1, then 1/16 at divisor 2
      for (int ph = 0; ph < 2; ph++) begin
         ctl = 8'h07;
         ctl.tx_pulse_width_select = ph[0];
         wr(`IRM_ADDR_CTRL, ctl); // enables off first
         wr(`IRM_ADDR_DIV, 8'(ph + 1)); // integer divisor only
         rd(`IRM_ADDR_DIV, 8'(ph + 1));
         w = ph ? 16'h0003 : 16'h0006;
         // fill the fifo while the modulator is off
         tx_bit_valid <= 1'b1;
         n = 0;
         repeat (12) begin
            tx_bit_data <= seed[0];
            @(posedge mclk);
            if (tx_bit_ready === 1'b1) begin
               n++;
               if (!seed[0]) tx_q.push_back(w);
               seed = lfsr_next(seed);
            end
         end
         tx_bit_valid <= 1'b0;
         @(posedge mclk);
         chk(16'(n), 16'(DEPTH));
         rd(`IRM_ADDR_STAT, 8'h02);
         ctl.ir_transmit_enable = 1'b1;
         ctl.ir_receive_enable = 1'b1;
         wr(`IRM_ADDR_CTRL, ctl); // same width, enables on
         rd(`IRM_ADDR_CTRL, ctl);
         // two framed characters behind the stored bits
         tx_bit_valid <= 1'b1;
         for (int k = 0; k < 20; k++) begin
            b = (k % 10 == 9) ? 1'b1 : (k % 10 == 0) ? 1'b0 : seed[0]; // start, 8 data, stop
            seed = lfsr_next(seed);
            tx_bit_data <= b;
            if (!b) tx_q.push_back(w);
            do @(posedge mclk); while (tx_bit_ready !== 1'b1);
         end
         tx_bit_valid <= 1'b0;
         repeat (500) @(posedge mclk);
         chk(16'(tx_q.size()), 16'h0000);
         ctl.ir_transmit_enable = 1'b0;
         ctl.ir_receive_enable = 1'b0;
         wr(`IRM_ADDR_CTRL, ctl); // same fields, enables off before the next change
      end
      // receive: each polarity, narrowest code 0 and code 7, just short and just enough
      for (int pol = 0; pol < 2; pol++) begin
         for (int code = 0; code < 8; code += 7) begin
            ctl = 8'(code);
            ctl.rx_pulse_polarity_select = pol[0];
            idle_lvl <= pol[0]; // line settles while the receiver is off
            wr(`IRM_ADDR_CTRL, ctl);
            ctl.ir_receive_enable = 1'b1;
            wr(`IRM_ADDR_CTRL, ctl);
            repeat (8) @(posedge mclk);
            mn = (code + 1) * 2;
            for (int len = mn - 1; len <= mn; len++) begin
               f0 = n_falls;
               xcvr_u.send_pulse(len);
               repeat (80) @(posedge mclk);
               chk(16'(n_falls - f0), 16'(len >= mn));
               chk({15'h0000, uart_rxd}, 16'h0001);
            end
            ctl.ir_receive_enable = 1'b0;
            wr(`IRM_ADDR_CTRL, ctl); // same fields, enables off
         end
      end
      close_out();
   end
endmodule // tb_top

// >>> design/irm_fifo.sv
`timescale 1ns/10ps
// ****************************************
// small synchronous fifo with registered ready
// ****************************************
module irm_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage array
   logic [AW-1:0] wr_ptr_r; // write pointer
   logic [AW-1:0] rd_ptr_r; // read pointer
   logic [AW:0] count_r; // words held
   logic [AW:0] count_nxt;
   logic ready_r; // not full, registered
   wire push_w = in_valid && ready_r; // word accepted
   wire pop_w = out_valid && out_ready; // word taken
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign in_ready = ready_r;
   assign count_nxt = count_r + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};
   // storage write, no reset needed
   always_ff @(posedge mclk) begin
      if (push_w) begin
         mem[wr_ptr_r] <= in_data;
      end
   end
   // pointers, fill level and ready
   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         ready_r <= 1'b0;
      end else begin
         wr_ptr_r <= push_w ? AW'((wr_ptr_r + 1'b1) % DEPTH) : wr_ptr_r;
         rd_ptr_r <= pop_w ? AW'((rd_ptr_r + 1'b1) % DEPTH) : rd_ptr_r;
         count_r <= count_nxt;
         ready_r <= (count_nxt != (AW+1)'(DEPTH));
      end
   end
endmodule // irm_fifo

// >>> design/irm_modem.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "irm_defs.svh"
module irm_modem import irm_pkg::*; #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic tx_bit_valid,
   input wire logic tx_bit_data,
   output logic tx_bit_ready,
   output logic ir_tx_pin,
   input wire logic ir_rx_pin,
   output logic uart_rxd
);
   // ****************************************
   // register file
   // ****************************************
   irm_ctrl_t ctrl_r; // infrared_control_reg
   logic [7:0] div_r; // baud generator divisor
   logic [7:0] rdata_r; // read data, one cycle after strobe
   irm_stat_t stat_w; // live status
   logic [7:0] rdata_nxt;
   wire sel_ctrl_w = (reg_addr == `IRM_ADDR_CTRL); // address decode
   wire sel_div_w = (reg_addr == `IRM_ADDR_DIV);
   wire sel_stat_w = (reg_addr == `IRM_ADDR_STAT);
   // read mux, unmapped addresses read zero
   assign rdata_nxt = sel_ctrl_w ? ctrl_r :
                      sel_div_w ? div_r :
                      sel_stat_w ? stat_w : `IRM_READ_ZERO;
   // register writes and read capture
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_r <= `IRM_CTRL_RST;
         div_r <= `IRM_DIV_RST;
         rdata_r <= `IRM_READ_ZERO;
      end else begin
         if (reg_wr && sel_ctrl_w) begin
            ctrl_r <= reg_wdata;
         end
         if (reg_wr && sel_div_w) begin
            div_r <= reg_wdata;
         end
         rdata_r <= reg_rd ? rdata_nxt : `IRM_READ_ZERO;
      end
   end
   assign reg_rdata = rdata_r;
   // ****************************************
   // baud generator: one tick per 1/16 bit
   // ****************************************
   logic [7:0] div_cnt_r; // input clocks within a tick
   wire tick_w = (div_cnt_r == div_r); // sixteenth of a bit elapsed
   // divider counter
   always_ff @(posedge mclk) begin
      if (reset) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= tick_w ? '0 : div_cnt_r + 8'h01;
      end
   end
   // ****************************************
   // transmit path: bit fifo and modulator
   // ****************************************
   irm_tx_state_t tx_state_r; // sequencer state
   irm_tx_state_t tx_state_nxt;
   logic [3:0] sub_r; // tick within current bit
   logic [3:0] sub_nxt;
   logic cur_bit_r; // bit being sent
   logic pin_r; // registered transmit pin
   logic fifo_valid_w; // a bit is waiting
   logic fifo_data_w; // the waiting bit
   wire tx_en_w = ctrl_r.ir_transmit_enable;
   wire bit_end_w = (tx_state_r == IRM_TX_BIT) && (sub_r == `IRM_TICKS_PER_BIT);
   wire can_start_w = tx_en_w && fifo_valid_w && ((tx_state_r == IRM_TX_IDLE) || bit_end_w);
   wire pop_w = tick_w && can_start_w; // take next bit at bit boundary
   wire [3:0] width_w = ctrl_r.tx_pulse_width_select ? `IRM_PULSE_1_16 : `IRM_PULSE_3_16;
   // pulse only for a zero bit, inside the chosen width
   wire pin_nxt = (tx_state_r == IRM_TX_BIT) && !cur_bit_r && (sub_r < width_w);
   irm_fifo #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .in_valid(tx_bit_valid),
      .in_data(tx_bit_data),
      .in_ready(tx_bit_ready),
      .out_valid(fifo_valid_w),
      .out_data(fifo_data_w),
      .out_ready(pop_w)
   );
   // sequencer next state
   always_comb begin
      tx_state_nxt = tx_state_r;
      sub_nxt = sub_r;
      unique case (tx_state_r)
         IRM_TX_IDLE: begin
            if (pop_w) begin
               tx_state_nxt = IRM_TX_BIT;
               sub_nxt = '0;
            end
         end
         IRM_TX_BIT: begin
            if (tick_w) begin
               sub_nxt = sub_r + 4'h1;
               if (bit_end_w) begin
                  tx_state_nxt = pop_w ? IRM_TX_BIT : IRM_TX_IDLE;
                  sub_nxt = '0;
               end
            end
         end
      endcase
   end
   // sequencer registers and pin
   always_ff @(posedge mclk) begin
      if (reset) begin
         tx_state_r <= IRM_TX_IDLE;
         sub_r <= '0;
         cur_bit_r <= 1'b1;
         pin_r <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         sub_r <= sub_nxt;
         cur_bit_r <= pop_w ? fifo_data_w : cur_bit_r;
         pin_r <= pin_nxt;
      end
   end
   assign ir_tx_pin = pin_r;
   // ****************************************
   // receive path: synchroniser and qualifier
   // ****************************************
   logic rx_s1_r; // first sync stage
   logic rx_s2_r; // second sync stage
   logic [4:0] run_r; // active length in input clocks
   logic rx_busy_r; // zero being presented
   logic [3:0] hold_r; // ticks of the presented zero
   logic rxd_r; // registered output to the serial channel
   wire rx_en_w = ctrl_r.ir_receive_enable;
   wire act_w = rx_en_w && (rx_s2_r ^ ctrl_r.rx_pulse_polarity_select);
   // one bit wider than the run counter so the widest code does not wrap to zero
   wire [5:0] min_w = ({2'b00, ctrl_r.rx_min_width} << `IRM_RXW_SCALE_SHIFT) + `IRM_RXW_OFFSET;
   wire qual_w = act_w && ({1'b0, run_r} == min_w - 6'h01);
   wire release_w = rx_busy_r && tick_w && (hold_r == `IRM_TICKS_PER_BIT);
   // two-stage synchroniser
   always_ff @(posedge mclk) begin
      if (reset) begin
         rx_s1_r <= 1'b0;
         rx_s2_r <= 1'b0;
      end else begin
         rx_s1_r <= ir_rx_pin;
         rx_s2_r <= rx_s1_r;
      end
   end
   // pulse length counter, saturating
   always_ff @(posedge mclk) begin
      if (reset) begin
         run_r <= '0;
      end else if (!act_w) begin
         run_r <= '0;
      end else if (run_r != 5'h1F) begin
         run_r <= run_r + 5'h01;
      end
   end
   // zero toward the serial channel for one bit time
   always_ff @(posedge mclk) begin
      if (reset || !rx_en_w) begin
         rx_busy_r <= 1'b0;
         hold_r <= '0;
         rxd_r <= 1'b1;
      end else if (qual_w) begin
         rx_busy_r <= 1'b1;
         hold_r <= '0;
         rxd_r <= 1'b0;
      end else if (release_w) begin
         rx_busy_r <= 1'b0;
         rxd_r <= 1'b1;
      end else if (rx_busy_r && tick_w) begin
         hold_r <= hold_r + 4'h1;
      end
   end
   assign uart_rxd = rxd_r;
   // status view
   assign stat_w = '{zero: 4'h0, rx_active: act_w, rx_zero: !rxd_r,
                     fifo_nonempty: fifo_valid_w, tx_busy: (tx_state_r == IRM_TX_BIT)};
   // ****************************************
   // checks
   // ****************************************
   logic [11:0] hi_len_r; // input clocks the pin has been high
   logic [3:0] hi_ticks_r; // ticks while high
   always_ff @(posedge mclk) begin
      if (reset || !pin_r) begin
         hi_len_r <= '0;
         hi_ticks_r <= '0;
      end else begin
         hi_len_r <= hi_len_r + 12'h001;
         hi_ticks_r <= hi_ticks_r + {3'b000, tick_w};
      end
   end
   a_pulse_cycles: assert property (@(posedge mclk) disable iff (reset)
      $fell(pin_r) && $stable(div_r) && $stable(ctrl_r) |->
      $past(hi_len_r) + 12'h001 == 12'(width_w) * (12'(div_r) + 12'h001))
      else $error("transmit pulse length wrong");
   a_pulse_nominal: assert property (@(posedge mclk) disable iff (reset)
      $fell(pin_r) && !ctrl_r.tx_pulse_width_select && $stable(ctrl_r) |-> hi_ticks_r == `IRM_PULSE_3_16)
      else $error("nominal pulse not three sixteenths");
   a_one_stays_low: assert property (@(posedge mclk) disable iff (reset)
      pin_r |-> $past(!cur_bit_r && tx_state_r == IRM_TX_BIT))
      else $error("pulse emitted for a one bit");
   a_rx_zero_out: assert property (@(posedge mclk) disable iff (reset)
      qual_w |=> !uart_rxd ##1 (!uart_rxd || !rx_en_w || $past(release_w)))
      else $error("qualified pulse did not give zero");
   a_rx_short_one: assert property (@(posedge mclk) disable iff (reset)
      $rose(act_w) ##1 !act_w && !rx_busy_r && min_w > 6'h01 |=> uart_rxd)
      else $error("short pulse gave zero");
   a_rx_polarity: assert property (@(posedge mclk) disable iff (reset)
      rx_en_w && (rx_s2_r == ctrl_r.rx_pulse_polarity_select) |=> run_r == 5'h00)
      else $error("inactive level counted as pulse");
   c_zero_sent: cover property (@(posedge mclk) disable iff (reset) $fell(pin_r));
   c_rx_zero: cover property (@(posedge mclk) disable iff (reset) qual_w);
   c_fifo_full: cover property (@(posedge mclk) disable iff (reset) tx_bit_valid && !tx_bit_ready);
endmodule // irm_modem

// >>> inc/irm_defs.svh
`ifndef IRM_DEFS_SVH
`define IRM_DEFS_SVH
// ****************************************
// register map (byte addresses, 8-bit data)
// ****************************************
`define IRM_ADDR_CTRL 8'h00
`define IRM_ADDR_DIV 8'h01
`define IRM_ADDR_STAT 8'h02
// ****************************************
// reset values
// ****************************************
`define IRM_CTRL_RST 8'h00
`define IRM_DIV_RST 8'h00
`define IRM_READ_ZERO 8'h00
// ****************************************
// bit timing in baud-generator ticks
// ****************************************
`define IRM_TICKS_PER_BIT 4'hF
`define IRM_PULSE_3_16 4'h3
`define IRM_PULSE_1_16 4'h1
// ****************************************
// receive qualifier: minimum = (field + 1) * 2 input clocks
// ****************************************
`define IRM_RXW_SCALE_SHIFT 1
`define IRM_RXW_OFFSET 6'h02
`endif

// >>> inc/irm_pkg.sv
// ****************************************
// shared types of the infrared modem
// ****************************************
package irm_pkg;
   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic rx_pulse_polarity_select; // 1: low-going pulses are active
      logic tx_pulse_width_select; // 1: 1/16 pulse, 0: 3/16 pulse
      logic ir_transmit_enable; // modulator on
      logic ir_receive_enable; // demodulator on
      logic [3:0] rx_min_width; // receive width code
   } irm_ctrl_t;
   // status register layout
   typedef struct packed {
      logic [3:0] zero; // reads as zero
      logic rx_active; // received line at active level
      logic rx_zero; // zero presented to the serial channel
      logic fifo_nonempty; // bits waiting to be sent
      logic tx_busy; // a bit period is in progress
   } irm_stat_t;
   // transmit sequencer
   typedef enum logic [0:0] {
      IRM_TX_IDLE = 1'b0,
      IRM_TX_BIT = 1'b1
   } irm_tx_state_t;
endpackage
